// file: ifa_consts.vh
// Constants for the input function assignment block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef IFA_CONSTS_VH
`define IFA_CONSTS_VH

// Register byte offsets
`define IFA_ADDR_ASSIGN_LO 8'h00
`define IFA_ADDR_ASSIGN_HI 8'h04
`define IFA_ADDR_POLARITY 8'h08
`define IFA_ADDR_NET_IN 8'h0c
`define IFA_ADDR_FUNC_STAT 8'h10
`define IFA_ADDR_FLAG_STAT 8'h14
`define IFA_ADDR_TERM_STAT 8'h18
`define IFA_ADDR_EVENT_STAT 8'h1c

// Reset values of the assignment codes, terminal 0 first
`define IFA_RST_ASSIGN_LO 32'h31300403
`define IFA_RST_ASSIGN_HI 32'h18121032
`define IFA_RST_POLARITY 8'h00
`define IFA_RST_NET_IN 32'h00000000

// Assignment codes
`define IFA_CODE_UNUSED 6'h00
`define IFA_CODE_CONT_POS 6'h01
`define IFA_CODE_CONT_NEG 6'h02
`define IFA_CODE_HOME 6'h03
`define IFA_CODE_POS_START 6'h04
`define IFA_CODE_SEQ_START 6'h05
`define IFA_CODE_JOG_POS 6'h06
`define IFA_CODE_JOG_NEG 6'h07
`define IFA_CODE_DIRECT_SEL0 6'h08
`define IFA_CODE_DIRECT_SEL5 6'h0d
`define IFA_CODE_FREE_RUN 6'h10
`define IFA_CODE_EXCITE_CTRL 6'h11
`define IFA_CODE_STOP 6'h12
`define IFA_CODE_ALARM_RESET 6'h18
`define IFA_CODE_POS_PRESET 6'h19
`define IFA_CODE_PANEL_RELEASE 6'h1b
`define IFA_CODE_FLAG0 6'h20
`define IFA_CODE_FLAG15 6'h2f
`define IFA_CODE_OPSEL0 6'h30
`define IFA_CODE_OPSEL5 6'h35

// Function vector bit positions
`define IFA_FN_CONT_POS 0
`define IFA_FN_CONT_NEG 1
`define IFA_FN_HOME 2
`define IFA_FN_POS_START 3
`define IFA_FN_SEQ_START 4
`define IFA_FN_JOG_POS 5
`define IFA_FN_JOG_NEG 6
`define IFA_FN_FREE_RUN 7
`define IFA_FN_EXCITE_CTRL 8
`define IFA_FN_STOP 9
`define IFA_FN_ALARM_RESET 10
`define IFA_FN_POS_PRESET 11
`define IFA_FN_PANEL_RELEASE 12
`define IFA_FN_WIDTH 13

`endif

// file: ifa_input_assign.v
// Input function assignment: routes eight input terminals and network inputs
// to function requests. Assumes a classic Wishbone master on i_clk and
// asynchronous terminal levels from the input connector.
// Limitation: no debounce beyond two agreeing synchroniser stages.
// Every function output is registered, so it lags the combined level by one edge.
`timescale 1ns/1ps
`include "ifa_consts.vh"

// Summary of operation
// - Eight terminals, each with an assignment code
// - Direct inputs from connector, separate from network
// - Same functions and flags also accepted as network inputs, but not direct select or op select
// - Code zero: terminal drives nothing
// - Codes 1/2: continuous positive/negative motion
// - Codes 6/7: jog positive/negative
// - Code 16: free-run, excitation off, brake released
// - Code 17: excitation control request
// - Codes 32-47: general flags 0 to 15
// - Codes 48-53: six-bit operation data select
// - Duplicate assignment: any active terminal activates
// - Alarm reset and preset act on rising edge
// - Panel release: unassigned on, both sides ANDed
// - Per-terminal polarity, 1 inverts, resets to 0
module ifa_input_assign #(
	parameter N_TERM = 8
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire [N_TERM-1:0] i_input_connector,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	output reg o_continuous_positive,
	output reg o_continuous_negative,
	output reg o_home_request,
	output reg o_positioning_start,
	output reg o_sequential_positioning_start,
	output reg o_jog_positive,
	output reg o_jog_negative,
	output reg [5:0] o_direct_positioning_select,
	output reg o_free_run_request,
	output reg o_excitation_control_request,
	output reg o_stop_request,
	output reg o_alarm_reset_pulse,
	output reg o_position_preset_pulse,
	output reg o_front_panel_release,
	output reg [15:0] o_general_flag,
	output reg [5:0] o_op_data_select
);

////////////////////////////////////////////////////////////////////////////////
// Decode one code into a function, flag, direct-select and op-select vector.
// Unlisted codes fall into no range and so drive nothing.
function [`IFA_FN_WIDTH+28-1:0] ifa_decode;
	input [5:0] code;
	reg [`IFA_FN_WIDTH-1:0] fn;
	reg [15:0] fl;
	reg [5:0] ds;
	reg [5:0] os;
	begin
		fn = {`IFA_FN_WIDTH{1'b0}};
		fl = 16'h0000;
		ds = 6'h00;
		os = 6'h00;
		// Direct-select and op-select ranges start on multiples of eight, so
		// their low three bits give the bit index; flags use the low four.
		if (code == `IFA_CODE_CONT_POS) fn[`IFA_FN_CONT_POS] = 1'b1;
		else if (code == `IFA_CODE_CONT_NEG) fn[`IFA_FN_CONT_NEG] = 1'b1;
		else if (code == `IFA_CODE_HOME) fn[`IFA_FN_HOME] = 1'b1;
		else if (code == `IFA_CODE_POS_START) fn[`IFA_FN_POS_START] = 1'b1;
		else if (code == `IFA_CODE_SEQ_START) fn[`IFA_FN_SEQ_START] = 1'b1;
		else if (code == `IFA_CODE_JOG_POS) fn[`IFA_FN_JOG_POS] = 1'b1;
		else if (code == `IFA_CODE_JOG_NEG) fn[`IFA_FN_JOG_NEG] = 1'b1;
		else if (code >= `IFA_CODE_DIRECT_SEL0 && code <= `IFA_CODE_DIRECT_SEL5)
			ds[code[2:0] - 3'd0] = 1'b1;
		else if (code == `IFA_CODE_FREE_RUN) fn[`IFA_FN_FREE_RUN] = 1'b1;
		else if (code == `IFA_CODE_EXCITE_CTRL) fn[`IFA_FN_EXCITE_CTRL] = 1'b1;
		else if (code == `IFA_CODE_STOP) fn[`IFA_FN_STOP] = 1'b1;
		else if (code == `IFA_CODE_ALARM_RESET) fn[`IFA_FN_ALARM_RESET] = 1'b1;
		else if (code == `IFA_CODE_POS_PRESET) fn[`IFA_FN_POS_PRESET] = 1'b1;
		else if (code == `IFA_CODE_PANEL_RELEASE) fn[`IFA_FN_PANEL_RELEASE] = 1'b1;
		else if (code >= `IFA_CODE_FLAG0 && code <= `IFA_CODE_FLAG15)
			fl[code[3:0]] = 1'b1;
		else if (code >= `IFA_CODE_OPSEL0 && code <= `IFA_CODE_OPSEL5)
			os[code[2:0]] = 1'b1;
		ifa_decode = {os, ds, fl, fn};
	end
endfunction

// Direct-select codes 8..13: bit index is code minus 8
// Kept apart so the routing loop uses one shared subtraction.
function [2:0] ifa_ds_idx;
	input [5:0] code;
	reg [5:0] t;
	begin
		t = code - `IFA_CODE_DIRECT_SEL0;
		ifa_ds_idx = t[2:0];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Configuration registers
// Register map, byte offsets, 32-bit words:
//   0x00 codes of terminals 0..3, one byte each, low six bits used
//   0x04 codes of terminals 4..7, same layout
//   0x08 polarity, one bit per terminal, 1 inverts the level
//   0x0c network inputs: functions in [12:0], general flags in [31:16]
//   0x10 status: combined functions, op select, direct select
//   0x14 status: general flags as driven
//   0x18 status: synchronised raw terminal levels
//   0x1c sticky edge record, alarm reset [0], preset [1], write 1 clears
// Codes are stored as six bits; the top two bits of each byte read zero.
// Offsets outside this list read zero and ignore writes.
// The sync and edge registers below are seen by software only
// through the status offsets.
reg [31:0] assign_lo_q;
reg [31:0] assign_hi_q;
reg [N_TERM-1:0] polarity_q;
reg [31:0] net_in_q;
reg [N_TERM-1:0] sync1_q;
reg [N_TERM-1:0] sync2_q;
reg [N_TERM-1:0] sync3_q;
reg [N_TERM-1:0] term_q;
reg [1:0] event_q;
reg alarm_prev_q;
reg preset_prev_q;

wire [63:0] assign_all = {assign_hi_q, assign_lo_q};
wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

// Byte-lane merge for a write
// Lanes not selected keep their old contents; a partial write of a code
// word leaves the other terminals' codes alone.
function [31:0] ifa_merge;
	input [31:0] old;
	input [31:0] dat;
	input [3:0] sel;
	integer b;
	begin
		ifa_merge = old;
		for (b = 0; b < 4; b = b + 1) begin
			if (sel[b]) ifa_merge[8*b +: 8] = dat[8*b +: 8];
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Stages two and three agreeing means the level has stood for two edges;
// a disagreement keeps the last accepted level, so a one-cycle glitch never
// reaches the routing. Stage one is read by stage two only, since its
// output may still be settling.
wire [N_TERM-1:0] sync_agree = ~(sync2_q ^ sync3_q);

// Terminal synchroniser; level accepted once stages two and three agree
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		sync1_q <= {N_TERM{1'b0}};
		sync2_q <= {N_TERM{1'b0}};
		sync3_q <= {N_TERM{1'b0}};
		term_q <= {N_TERM{1'b0}};
	end else begin
		sync1_q <= i_input_connector;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
		term_q <= (term_q & ~sync_agree) | (sync2_q & sync_agree);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Routing: OR of every terminal that holds a code (duplicates merge)
// Latency: the outputs follow a pin four edges after the first stage takes
// it, and a network write one edge after the edge that takes the write.
// Polarity is applied before routing, so a normally closed contact reads
// as active while it is open. Unlisted codes decode to zero and add nothing.
// Several terminals on one code simply OR together; software should avoid it.
// The OR covers flags and both select words the same way.
reg [`IFA_FN_WIDTH-1:0] dir_fn;
reg [15:0] dir_flag;
reg [5:0] dir_ds;
reg [5:0] dir_os;
reg panel_assigned;
reg [`IFA_FN_WIDTH+28-1:0] dec;
reg [5:0] code;
reg active;
integer t;
always @* begin
	dir_fn = {`IFA_FN_WIDTH{1'b0}};
	dir_flag = 16'h0000;
	dir_ds = 6'h00;
	dir_os = 6'h00;
	panel_assigned = 1'b0;
	dec = {(`IFA_FN_WIDTH+28){1'b0}};
	code = 6'h00;
	active = 1'b0;
	for (t = 0; t < N_TERM; t = t + 1) begin
		code = assign_all[8*t +: 6];
		active = term_q[t] ^ polarity_q[t];
		dec = ifa_decode(code);
		// Direct-select index rebuilt through the shared offset helper
		if (code >= `IFA_CODE_DIRECT_SEL0 && code <= `IFA_CODE_DIRECT_SEL5) begin
			dec[`IFA_FN_WIDTH+16 +: 6] = 6'h00;
			dec[`IFA_FN_WIDTH+16 + ifa_ds_idx(code)] = 1'b1;
		end
		// Panel counts as assigned even on an inactive terminal
		if (code == `IFA_CODE_PANEL_RELEASE) panel_assigned = 1'b1;
		if (active) begin
			dir_fn = dir_fn | dec[`IFA_FN_WIDTH-1:0];
			dir_flag = dir_flag | dec[`IFA_FN_WIDTH +: 16];
			dir_ds = dir_ds | dec[`IFA_FN_WIDTH+16 +: 6];
			dir_os = dir_os | dec[`IFA_FN_WIDTH+22 +: 6];
		end
	end
end

// Network input word: functions in [12:0], flags [31:16]. It carries no
// op-select or direct-select bits; those come from the terminals only.
wire [`IFA_FN_WIDTH-1:0] net_fn = net_in_q[`IFA_FN_WIDTH-1:0];
wire [15:0] net_flag = net_in_q[31:16];
wire net_panel_on = net_in_q[`IFA_FN_PANEL_RELEASE];
wire [`IFA_FN_WIDTH-1:0] comb_fn = dir_fn | net_fn;
// Panel release: with no terminal holding its code it stays on whatever the
// network says; once assigned, the direct level and the network bit must
// both be on
wire panel_dir_on = panel_assigned ? dir_fn[`IFA_FN_PANEL_RELEASE] : 1'b1;
wire panel_net_on = panel_assigned ? net_panel_on : 1'b1;
wire panel_d = panel_dir_on & panel_net_on;
// Edge-acting levels combine both sides before the edge detector
wire alarm_lvl = comb_fn[`IFA_FN_ALARM_RESET];
wire preset_lvl = comb_fn[`IFA_FN_POS_PRESET];

////////////////////////////////////////////////////////////////////////////////
// Function outputs, all registered; edge-acting requests become pulses
// Edges are taken against the previous combined level, so writing an
// edge-acting code onto a terminal that is already on also counts as an edge.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		// Outputs idle low; panel release rises at the first edge if unassigned
		o_continuous_positive <= 1'b0;
		o_continuous_negative <= 1'b0;
		o_home_request <= 1'b0;
		o_positioning_start <= 1'b0;
		o_sequential_positioning_start <= 1'b0;
		o_jog_positive <= 1'b0;
		o_jog_negative <= 1'b0;
		o_direct_positioning_select <= 6'h00;
		o_free_run_request <= 1'b0;
		o_excitation_control_request <= 1'b0;
		o_stop_request <= 1'b0;
		o_alarm_reset_pulse <= 1'b0;
		o_position_preset_pulse <= 1'b0;
		o_front_panel_release <= 1'b0;
		o_general_flag <= 16'h0000;
		o_op_data_select <= 6'h00;
		alarm_prev_q <= 1'b0;
		preset_prev_q <= 1'b0;
		event_q <= 2'b00;
	end else begin
		// Levels
		o_continuous_positive <= comb_fn[`IFA_FN_CONT_POS];
		o_continuous_negative <= comb_fn[`IFA_FN_CONT_NEG];
		o_home_request <= comb_fn[`IFA_FN_HOME];
		o_positioning_start <= comb_fn[`IFA_FN_POS_START];
		o_sequential_positioning_start <= comb_fn[`IFA_FN_SEQ_START];
		o_jog_positive <= comb_fn[`IFA_FN_JOG_POS];
		o_jog_negative <= comb_fn[`IFA_FN_JOG_NEG];
		o_direct_positioning_select <= dir_ds;
		o_free_run_request <= comb_fn[`IFA_FN_FREE_RUN];
		o_excitation_control_request <= comb_fn[`IFA_FN_EXCITE_CTRL];
		o_stop_request <= comb_fn[`IFA_FN_STOP];
		o_front_panel_release <= panel_d;
		o_general_flag <= dir_flag | net_flag;
		o_op_data_select <= dir_os;
		// Edge detection; pulses last one cycle
		alarm_prev_q <= alarm_lvl;
		preset_prev_q <= preset_lvl;
		o_alarm_reset_pulse <= alarm_lvl & ~alarm_prev_q;
		o_position_preset_pulse <= preset_lvl & ~preset_prev_q;
		// Sticky event record; a new edge wins over a clear in the same cycle
		// Software reads the record to catch an edge the one-cycle pulses show
		// too briefly; a clear needs byte lane 0.
		if (wb_req && i_wb_we && i_wb_adr == `IFA_ADDR_EVENT_STAT && i_wb_sel[0])
			event_q <= (event_q & ~i_wb_dat[1:0]) |
				{preset_lvl & ~preset_prev_q, alarm_lvl & ~alarm_prev_q};
		else
			event_q <= event_q | {preset_lvl & ~preset_prev_q, alarm_lvl & ~alarm_prev_q};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave: one wait-free ack per request, unmapped reads return zero
// Ack rises on the taking edge itself and lasts one cycle; the ~ack
// term in the request keeps a strobe held into the ack cycle from being taken again in that cycle. Writes to
// status offsets 0x10 to 0x18 and unmapped offsets are acked and dropped; a write to 0x1c clears events.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		// Reset codes give each terminal its factory function
		assign_lo_q <= `IFA_RST_ASSIGN_LO;
		assign_hi_q <= `IFA_RST_ASSIGN_HI;
		polarity_q <= `IFA_RST_POLARITY;
		net_in_q <= `IFA_RST_NET_IN;
		o_wb_ack <= 1'b0;
		o_wb_dat <= 32'h00000000;
	end else begin
		o_wb_ack <= wb_req;
		// Writes; polarity needs byte lane 0
		if (wb_req && i_wb_we) begin
			if (i_wb_adr == `IFA_ADDR_ASSIGN_LO)
				assign_lo_q <= ifa_merge(assign_lo_q, i_wb_dat, i_wb_sel) & 32'h3f3f3f3f;
			else if (i_wb_adr == `IFA_ADDR_ASSIGN_HI)
				assign_hi_q <= ifa_merge(assign_hi_q, i_wb_dat, i_wb_sel) & 32'h3f3f3f3f;
			else if (i_wb_adr == `IFA_ADDR_POLARITY && i_wb_sel[0])
				polarity_q <= i_wb_dat[N_TERM-1:0];
			else if (i_wb_adr == `IFA_ADDR_NET_IN)
				net_in_q <= ifa_merge(net_in_q, i_wb_dat, i_wb_sel) & 32'hffff1fff;
		end
		// Reads; the function bits of the status show the level the outputs take next, the select fields the current outputs
		if (wb_req && !i_wb_we) begin
			if (i_wb_adr == `IFA_ADDR_ASSIGN_LO)
				o_wb_dat <= assign_lo_q;
			else if (i_wb_adr == `IFA_ADDR_ASSIGN_HI)
				o_wb_dat <= assign_hi_q;
			else if (i_wb_adr == `IFA_ADDR_POLARITY)
				o_wb_dat <= {24'h000000, polarity_q};
			else if (i_wb_adr == `IFA_ADDR_NET_IN)
				o_wb_dat <= net_in_q;
			else if (i_wb_adr == `IFA_ADDR_FUNC_STAT)
				o_wb_dat <= {7'h00, o_direct_positioning_select, o_op_data_select, comb_fn};
			else if (i_wb_adr == `IFA_ADDR_FLAG_STAT)
				o_wb_dat <= {16'h0000, o_general_flag};
			else if (i_wb_adr == `IFA_ADDR_TERM_STAT)
				o_wb_dat <= {24'h000000, term_q};
			else if (i_wb_adr == `IFA_ADDR_EVENT_STAT)
				o_wb_dat <= {30'h00000000, event_q};
			else
				o_wb_dat <= 32'h00000000;
		end
	end
end

endmodule

// file: ifa_input_assign_bench.sv
// Bench for ifa_input_assign: Wishbone host plus switch bank.
// Assumes the design files and checker are compiled first.
`timescale 1ns/1ps
module ifa_input_assign_bench;
	reg clk, rst_n, cyc, stb, we, bnc;
	reg [7:0] adr, tgt;
	reg [3:0] sel;
	reg [31:0] wdat, rd_v, l;
	reg [7:0] n;
	wire [7:0] pins;
	wire [31:0] rdat;
	wire ack, cp, cn, hm, ps, ss, jp, jn, fr, ex, sp, ar, pp, pr;
	wire [5:0] ds, os;
	wire [15:0] gf;
	wire [38:0] obs = {gf, os, ds, sp, ex, fr, jn, jp, ss, ps, hm, cn, cp, pr};
	integer err_count, checks, seed, i, cyc_cnt;
	always #12.5 clk = ~clk;
	ifa_switch_model sw_u (.i_clk(clk), .i_target(tgt), .i_bounce(bnc), .o_pins(pins));
	ifa_input_assign dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_input_connector(pins), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_continuous_positive(cp), .o_continuous_negative(cn), .o_home_request(hm),
		.o_positioning_start(ps), .o_sequential_positioning_start(ss), .o_jog_positive(jp),
		.o_jog_negative(jn), .o_direct_positioning_select(ds), .o_free_run_request(fr),
		.o_excitation_control_request(ex), .o_stop_request(sp), .o_alarm_reset_pulse(ar),
		.o_position_preset_pulse(pp), .o_front_panel_release(pr), .o_general_flag(gf), .o_op_data_select(os));
	////////////////////////////////////////////////////////////
	// Expected function vector; panel stays on unless code 27
	function automatic [38:0] expv(input [5:0] c, input a);
		reg [38:0] v;
		v = 39'h0;
		v[0] = c != 6'h1b;
		if (a) begin
			if (c >= 1 && c <= 7) v[c] = 1'b1;
			else if (c >= 8 && c <= 13) v[c + 3] = 1'b1;
			else if (c >= 16 && c <= 18) v[c - 8] = 1'b1;
			else if (c >= 32 && c <= 47) v[c - 9] = 1'b1;
			else if (c >= 48 && c <= 53) v[c - 31] = 1'b1;
		end
		return v;
	endfunction
	task check(input string nm, input [63:0] e, input [63:0] g);
		checks++;
		if (e !== g) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; waits for ack however long it takes
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do @(posedge clk); while (ack !== 1'b1);
		rd_v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task summarize;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog on total run length
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt > 20000) begin
			err_count++;
			summarize;
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		clk = 0; rst_n = 0; cyc = 0; stb = 0; we = 0; bnc = 0; adr = 0; tgt = 0; sel = 0; wdat = 0;
		err_count = 0; checks = 0; seed = 36; cyc_cnt = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wb(0, 8'h00, 0); check("assign_lo", 32'h31300403, rd_v);
		wb(0, 8'h04, 0); check("assign_hi", 32'h18121032, rd_v);
		wb(0, 8'h08, 0); check("polarity", 0, rd_v);
		wb(0, 8'h40, 0); check("unmapped", 0, rd_v);
		wb(1, 8'h04, 0);
		// Every code on terminal 0; other terminals unused but toggling
		for (i = 0; i < 64; i++) begin
			l = $random(seed);
			wb(1, 8'h00, i);
			wb(1, 8'h08, {31'h0, l[1]});
			tgt <= l[7:0];
			bnc <= l[2];
			repeat (14) @(posedge clk);
			check("functions", expv(i[5:0], l[0] ^ l[1]), obs);
			wb(0, 8'h18, 0); check("pins", {24'h0, l[7:0]}, rd_v);
		end
		wb(1, 8'h08, 0);
		bnc <= 1'b0;
		wb(1, 8'h00, 32'h06000006);
		tgt <= 8'h00;
		repeat (8) @(posedge clk);
		check("dup idle", 0, jp);
		tgt <= 8'h08;
		repeat (8) @(posedge clk);
		check("dup", 1, jp);
		tgt <= 8'h01;
		repeat (8) @(posedge clk);
		check("dup first", 1, jp);
		// Edge-only functions pulse once per press
		for (i = 24; i < 26; i++) begin
			wb(1, 8'h00, i);
			tgt <= 8'h00;
			repeat (6) @(posedge clk);
			tgt <= 8'h01;
			n = 0;
			repeat (20) begin
				@(posedge clk);
				n = n + ((i == 24) ? ar : pp);
			end
			check("edge pulses", 1, n);
		end
		wb(0, 8'h1c, 0); check("events", 3, rd_v);
		wb(1, 8'h1c, 32'h3);
		wb(0, 8'h1c, 0); check("event clear", 0, rd_v);
		wb(1, 8'h00, 32'h1b);
		wb(1, 8'h0c, 32'h00011001);
		repeat (4) @(posedge clk);
		check("net on", 39'h3 | (39'h1 << 23), obs);
		tgt <= 8'h00;
		repeat (8) @(posedge clk);
		check("net panel", 39'h2 | (39'h1 << 23), obs);
		summarize;
	end
endmodule
bind ifa_input_assign ifa_props chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_input_connector(i_input_connector),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .o_alarm_reset_pulse(o_alarm_reset_pulse), .o_position_preset_pulse(o_position_preset_pulse));

// file: ifa_props.sv
// Checker for the input function assignment bus and pulse outputs.
// Assumes binding onto the top module's ports, one clock domain.
`timescale 1ns/1ps
module ifa_props (
	input wire i_clk,
	input wire i_reset_n,
	input wire [7:0] i_input_connector,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [31:0] o_wb_dat,
	input wire o_wb_ack,
	input wire o_alarm_reset_pulse,
	input wire o_position_preset_pulse
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire rd = req && !i_wb_we;
	reg [7:0] prev_q;
	reg [3:0] stab_q;
	////////////////////////////////////////////////////////////
	// Pin quiet time; the synchroniser needs four edges to settle
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_q <= 8'h00;
			stab_q <= 4'h0;
		end else begin
			prev_q <= i_input_connector;
			stab_q <= (prev_q != i_input_connector) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hf};
		end
	end
	////////////////////////////////////////////////////////////
	ack_after_req_a: assert property (req |=> o_wb_ack) else $error("ack missing after request");
	ack_single_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
	ack_needs_req_a: assert property (!req |=> !o_wb_ack) else $error("ack without request");
	unmapped_zero_a: assert property (rd && i_wb_adr > 8'h1f |=> o_wb_dat == 32'h0) else $error("unmapped read");
	rdata_hold_a: assert property (!rd |=> $stable(o_wb_dat)) else $error("read data moved");
	term_status_a: assert property (rd && i_wb_adr == 8'h18 && stab_q > 4'h5 |=>
		o_wb_dat[7:0] == $past(i_input_connector)) else $error("terminal status wrong");
	alarm_pulse_a: assert property (o_alarm_reset_pulse |=> !o_alarm_reset_pulse) else $error("alarm pulse long");
	preset_pulse_a: assert property (o_position_preset_pulse |=> !o_position_preset_pulse) else $error("preset long");
	cover property (rd && i_wb_adr == 8'h18);
	cover property (req && i_wb_we);
	cover property (o_position_preset_pulse);
endmodule

// file: ifa_switch_model.sv
// Switch bank on the input connector.
// Assumes targets change just after rising edges.
`timescale 1ns/1ps
module ifa_switch_model (
	input wire i_clk,
	input wire [7:0] i_target,
	input wire i_bounce,
	output reg [7:0] o_pins
);
	wire [7:0] diff = o_pins ^ i_target;
	// Slow contacts settle one bit per cycle, lowest first
	always @(posedge i_clk) begin
		o_pins <= i_bounce ? o_pins ^ (diff & (~diff + 8'h01)) : i_target;
	end
endmodule
